// ### tb_tcc_client.sv
// Register-level bench for the two-wire client with a host model
`timescale 1ns/10ps
module tb_tcc_client;
  logic clk_in, rst_in, wr_in, rd_in, scl_out, scl_oe_out, sda_out, sda_oe_out, h_scl, h_sda, q;
  logic [3:0] addr_in;
  logic [7:0] wdata_in, rdata_out, v;
  int err_total = 0;
  int checked = 0;
  wire logic scl_w = h_scl & ~scl_oe_out;
  wire logic sda_w = h_sda & ~sda_oe_out;

  tcc_client u_tcc_client (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe_out(scl_oe_out), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe_out));
  tcc_host_model u_tcc_host_model (.clk_in(clk_in), .scl_in(scl_w), .sda_in(sda_w),
    .scl_out(h_scl), .sda_out(h_sda));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic summarize();
    err_total += u_tcc_host_model.hangs;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(name, rdata_out & m, e);
  endtask : rd_chk
  // Client answer bit: release SDA, compare what the client drove
  task automatic ack_chk(input logic e);
    u_tcc_host_model.xfer(1'b1, q);
    chk("ack bit", {7'h00, q}, {7'h00, e});
  endtask : ack_chk
  task automatic wait_hold();
    int n;
    n = 0;
    while (scl_oe_out !== 1'b1 && n < 60) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 60) begin
      err_total++;
      $display("unexpected clock hold: expected 1 seen 0");
      summarize();
    end
  endtask : wait_hold

  initial begin
    rst_in = 1'b1;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 4'h0;
    wdata_in = 8'h00;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int a = 9; a <= 13; a++) rd_chk("reset value", 4'(a), 8'hFF, 8'h00);
    rd_chk("unmapped", 4'hF, 8'hFF, 8'h00);
    wr(tcc_pkg::OFF_CMDC, 8'h07);
    rd_chk("command readback", tcc_pkg::OFF_CMDC, 8'hFF, 8'h04);
    wr(tcc_pkg::OFF_CMDC, 8'h00);
    wr(tcc_pkg::OFF_OWN, 8'hA0);
    rd_chk("own address", tcc_pkg::OFF_OWN, 8'hFF, 8'hA0);
    chk("pin drive levels", {6'h00, scl_out, sda_out}, 8'h00);
    wr(tcc_pkg::OFF_CTLA, 8'h23);
    $display("test done: registers");

    u_tcc_host_model.start();
    u_tcc_host_model.byte_x(8'hA0, v);
    wait_hold();
    rd_chk("status addr write", tcc_pkg::OFF_STAT, 8'hFF, 8'h61);
    wr(tcc_pkg::OFF_CMDC, 8'h03);
    ack_chk(1'b0);
    rd_chk("status released", tcc_pkg::OFF_STAT, 8'hE0, 8'h00);
    u_tcc_host_model.byte_x(8'h5A, v);
    wait_hold();
    rd_chk("status byte in", tcc_pkg::OFF_STAT, 8'hE0, 8'hA0);
    wr(tcc_pkg::OFF_DATA, 8'h11);
    rd_chk("status data write", tcc_pkg::OFF_STAT, 8'hE0, 8'h20);
    chk("sda drive", {7'h00, sda_oe_out}, 8'h00);
    wr(tcc_pkg::OFF_CMDC, 8'h03);
    ack_chk(1'b0);
    u_tcc_host_model.byte_x(8'hC3, v);
    wait_hold();
    rd_chk("data smart read", tcc_pkg::OFF_DATA, 8'hFF, 8'hC3);
    ack_chk(1'b0);
    u_tcc_host_model.byte_x(8'h3C, v);
    wait_hold();
    wr(tcc_pkg::OFF_CMDC, 8'h06);
    ack_chk(1'b1);
    u_tcc_host_model.stop();
    rd_chk("status stop", tcc_pkg::OFF_STAT, 8'h41, 8'h40);
    $display("test done: host write");

    u_tcc_host_model.start();
    u_tcc_host_model.byte_x(8'hA1, v);
    wait_hold();
    rd_chk("status addr read", tcc_pkg::OFF_STAT, 8'h63, 8'h63);
    wr(tcc_pkg::OFF_CMDC, 8'h00);
    rd_chk("status after nop", tcc_pkg::OFF_STAT, 8'h60, 8'h60);
    wr(tcc_pkg::OFF_CMDC, 8'h03);
    ack_chk(1'b0);
    wait_hold();
    rd_chk("status read event", tcc_pkg::OFF_STAT, 8'hE0, 8'hA0);
    wr(tcc_pkg::OFF_DATA, 8'h96);
    u_tcc_host_model.byte_x(8'hFF, v);
    chk("byte sent", v, 8'h96);
    u_tcc_host_model.xfer(1'b0, q);
    wait_hold();
    rd_chk("status host ack", tcc_pkg::OFF_STAT, 8'h90, 8'h80);
    wr(tcc_pkg::OFF_DATA, 8'hFF);
    u_tcc_host_model.byte_x(8'h7F, v);
    u_tcc_host_model.xfer(1'b1, q);
    wait_hold();
    rd_chk("status collision", tcc_pkg::OFF_STAT, 8'h98, 8'h98);
    wr(tcc_pkg::OFF_CMDC, 8'h02);
    rd_chk("status finished", tcc_pkg::OFF_STAT, 8'h28, 8'h08);
    $display("test done: host read");

    u_tcc_host_model.start();
    rd_chk("collision at start", tcc_pkg::OFF_STAT, 8'h08, 8'h00);
    u_tcc_host_model.stop();
    rd_chk("bus error", tcc_pkg::OFF_STAT, 8'h04, 8'h04);
    wr(tcc_pkg::OFF_STAT, 8'h04);
    rd_chk("bus error cleared", tcc_pkg::OFF_STAT, 8'h04, 8'h00);
    $display("test done: bus faults");

    wr(tcc_pkg::OFF_OWN, 8'hA1);
    u_tcc_host_model.start();
    u_tcc_host_model.byte_x(8'h00, v);
    wait_hold();
    rd_chk("status general call", tcc_pkg::OFF_STAT, 8'h63, 8'h61);
    wr(tcc_pkg::OFF_CMDC, 8'h07);
    u_tcc_host_model.xfer(1'b0, q);
    rd_chk("status blocked nack", tcc_pkg::OFF_STAT, 8'h6B, 8'h49);
    u_tcc_host_model.stop();
    rd_chk("status stop after ack", tcc_pkg::OFF_STAT, 8'h45, 8'h40);
    wr(tcc_pkg::OFF_CTLA, 8'h27);
    u_tcc_host_model.start();
    u_tcc_host_model.byte_x(8'h24, v);
    wait_hold();
    rd_chk("status permissive", tcc_pkg::OFF_STAT, 8'h69, 8'h61);
    $display("test done: general call and permissive");
    summarize();
  end
endmodule : tb_tcc_client

// ### tcc_client.sv
// Two-wire bus client: command, status, address registers and byte engine
// Contract
// - Smart mode: data read performs acknowledge action
// - Data register write never performs acknowledge
// - Ack select 0 sends ACK, 1 NACK
// - Command field is strobe, reads zero, 0 idle
// - Command 2 ends transaction, waits for start
// - Command 3 on address: ack, then data event
// - Command 3 on write data: ack, next byte
// - Ack select updates before same-write command
// - Data flag set on byte end or read address ack
// - Data access or nonzero command clears both events
// - Address flag set on address match or stop
// - Data and address-match events hold clock low, bit 5 shows it
// - Bit 4 holds last host acknowledge bit
// - Failed high data bit sets collision flag
// - Blocked NACK after match sets collision, address
// - Collision clears by writing one or start
// - Start/stop protocol violation sets bus error
// - Direction bit holds last address read/write bit
// - Cause bit: 0 stop, 1 address
// - Own address upper seven; bit 0 general call
// - Smart mode: write continues when sending data, read at any other wait; both clear event
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
module tcc_client (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Serial clock pin
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  // Serial data pin
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out
);

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    return a == off;
  endfunction : hit

  tcc_pkg::tcc_state_t st_r;
  tcc_pkg::tcc_state_t st_nxt;
  tcc_pkg::tcc_state_t tgt_r;
  tcc_pkg::tcc_state_t tgt_nxt;
  tcc_pkg::tcc_status_t stat_r;
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic [7:0] ctla_r;
  logic [7:0] own_r;
  logic [7:0] data_r;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [7:0] rd_mux;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic ack_r;
  logic nack_r;
  logic nack_nxt;
  logic wk_addr_r;
  logic wk_addr_nxt;
  logic abort_r;
  logic abort_nxt;
  logic addressed_r;
  logic dif_set;
  logic addr_stop_event_flag_adr;
  logic addr_stop_event_flag_stop;
  logic collision_flag_set;
  logic berr_set;
  logic dir_ld;
  logic host_ack_received_ld;
  logic sda_drv_nxt;

  // Pin edge and condition decode
  wire scl_s = scl_q[1];
  wire scl_p = scl_q[2];
  wire sda_s = sda_q[1];
  wire sda_p = sda_q[2];
  wire scl_rise = scl_s & ~scl_p;
  wire scl_fall = ~scl_s & scl_p;
  // Oversampled detection; clk must run at least 4x the serial clock
  wire start_det = scl_s & scl_p & sda_p & ~sda_s;
  wire stop_det = scl_s & scl_p & ~sda_p & sda_s;

  // Register access decode
  wire wr_ctla = wr_in & hit(addr_in, tcc_pkg::OFF_CTLA);
  wire wr_cmdc = wr_in & hit(addr_in, tcc_pkg::OFF_CMDC);
  wire wr_stat = wr_in & hit(addr_in, tcc_pkg::OFF_STAT);
  wire wr_own = wr_in & hit(addr_in, tcc_pkg::OFF_OWN);
  wire data_wr = wr_in & hit(addr_in, tcc_pkg::OFF_DATA);
  wire data_rd = rd_in & hit(addr_in, tcc_pkg::OFF_DATA);
  wire [1:0] cmd = wdata_in[1:0];
  wire cmd_wr = wr_cmdc & (cmd != tcc_pkg::CMD_NOP);
  wire cmd_done = wr_cmdc & (cmd == tcc_pkg::CMD_DONE);
  wire cmd_resp = wr_cmdc & (cmd == tcc_pkg::CMD_RESP);
  // Ack select written with a command is used by that command
  wire ack_eff = wr_cmdc ? wdata_in[tcc_pkg::B_ACK] : ack_r;
  wire smart = ctla_r[tcc_pkg::B_SMART];
  wire in_wait = st_r == tcc_pkg::ST_WAIT;
  wire rd_phase = stat_r.dir & ~wk_addr_r;
  wire clr_ev = data_rd | data_wr | cmd_wr;

  // Continuation requests while the clock is held
  wire ack_go = in_wait & ~rd_phase & (cmd_resp | (smart & data_rd));
  wire tx_go = in_wait & rd_phase & (cmd_resp | (smart & data_wr));
  wire done_go = in_wait & cmd_done;

  // Own address, general call and permissive match
  wire [6:0] rx_adr = sh_r[7:1];
  wire own_hit = rx_adr == own_r[7:1];
  wire gc_hit = own_r[0] & (rx_adr == tcc_pkg::GCALL_ADDR);
  wire addr_hit = ctla_r[tcc_pkg::B_PERM] | own_hit | gc_hit;
  // First rise of a received byte may be a legal repeated start or stop
  wire mid_byte = ((st_r == tcc_pkg::ST_TX || st_r == tcc_pkg::ST_ADDR) && cnt_r != 4'h0) ||
                  (st_r == tcc_pkg::ST_RX && cnt_r > 4'h1);
  // Stop after at most one clock pulse following a start
  wire bare_start = st_r == tcc_pkg::ST_ADDR && cnt_r <= 4'h1;

  // Byte engine
  always_comb begin
    st_nxt = st_r;
    tgt_nxt = tgt_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    nack_nxt = nack_r;
    wk_addr_nxt = wk_addr_r;
    abort_nxt = abort_r;
    dif_set = 1'h0;
    addr_stop_event_flag_adr = 1'h0;
    addr_stop_event_flag_stop = 1'h0;
    collision_flag_set = 1'h0;
    berr_set = 1'h0;
    dir_ld = 1'h0;
    host_ack_received_ld = 1'h0;
    case (st_r)
      tcc_pkg::ST_IDLE: begin
        cnt_nxt = tcc_pkg::RST_CNT;
      end
      tcc_pkg::ST_ADDR, tcc_pkg::ST_RX: begin
        if (scl_rise && cnt_r < tcc_pkg::BITS_BYTE) begin
          sh_nxt = {sh_r[6:0], sda_s};
          cnt_nxt = cnt_r + 4'h1;
        end else if (scl_fall && cnt_r == tcc_pkg::BITS_BYTE) begin
          cnt_nxt = tcc_pkg::RST_CNT;
          if (st_r == tcc_pkg::ST_RX) begin
            dif_set = 1'h1;
            st_nxt = tcc_pkg::ST_WAIT;
            wk_addr_nxt = 1'h0;
          end else if (addr_hit) begin
            addr_stop_event_flag_adr = 1'h1;
            dir_ld = 1'h1;
            st_nxt = tcc_pkg::ST_WAIT;
            wk_addr_nxt = 1'h1;
          end else begin
            st_nxt = tcc_pkg::ST_IDLE;
          end
        end
      end
      tcc_pkg::ST_ACKO: begin
        if (scl_rise) begin
          cnt_nxt = 4'h1;
          collision_flag_set = nack_r & ~sda_s;
          addr_stop_event_flag_adr = nack_r & ~sda_s & wk_addr_r;
        end else if (scl_fall && cnt_r != 4'h0) begin
          cnt_nxt = tcc_pkg::RST_CNT;
          st_nxt = tgt_r;
          dif_set = tgt_r == tcc_pkg::ST_WAIT;
          wk_addr_nxt = 1'h0;
        end
      end
      tcc_pkg::ST_TX: begin
        if (scl_rise && sh_r[7] && !abort_r && !sda_s) begin
          collision_flag_set = 1'h1;
          abort_nxt = 1'h1;
        end else if (scl_fall) begin
          sh_nxt = {sh_r[6:0], 1'h1};
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r == tcc_pkg::BITS_BYTE - 4'h1) begin
            st_nxt = tcc_pkg::ST_TACK;
            cnt_nxt = tcc_pkg::RST_CNT;
          end
        end
      end
      tcc_pkg::ST_TACK: begin
        if (scl_rise) begin
          host_ack_received_ld = 1'h1;
          cnt_nxt = 4'h1;
        end else if (scl_fall && cnt_r != 4'h0) begin
          cnt_nxt = tcc_pkg::RST_CNT;
          dif_set = 1'h1;
          st_nxt = tcc_pkg::ST_WAIT;
          wk_addr_nxt = 1'h0;
        end
      end
      tcc_pkg::ST_WAIT: begin
        if (ack_go || (done_go && !stat_r.dir)) begin
          st_nxt = tcc_pkg::ST_ACKO;
          cnt_nxt = tcc_pkg::RST_CNT;
          nack_nxt = ack_eff;
          if (done_go) begin
            tgt_nxt = tcc_pkg::ST_IDLE;
          end else if (stat_r.dir) begin
            tgt_nxt = tcc_pkg::ST_WAIT;
          end else begin
            tgt_nxt = tcc_pkg::ST_RX;
          end
        end else if (tx_go) begin
          st_nxt = tcc_pkg::ST_TX;
          cnt_nxt = tcc_pkg::RST_CNT;
          abort_nxt = 1'h0;
          sh_nxt = data_wr ? wdata_in : data_r;
        end else if (done_go) begin
          st_nxt = tcc_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt = tcc_pkg::ST_IDLE;
      end
    endcase
    if (start_det) begin
      berr_set = mid_byte;
      st_nxt = tcc_pkg::ST_ADDR;
      cnt_nxt = tcc_pkg::RST_CNT;
    end else if (stop_det) begin
      berr_set = mid_byte | bare_start;
      addr_stop_event_flag_stop = addressed_r & ctla_r[tcc_pkg::B_STOPIE];
      st_nxt = tcc_pkg::ST_IDLE;
    end
    if (!ctla_r[tcc_pkg::B_EN]) begin
      st_nxt = tcc_pkg::ST_IDLE;
    end
  end

  // Pin drive: ack bit, or a zero data bit when not aborted
  assign sda_drv_nxt = (st_nxt == tcc_pkg::ST_ACKO && !nack_nxt) ||
                       (st_nxt == tcc_pkg::ST_TX && !sh_nxt[7] && !abort_nxt);
  assign scl_out = 1'h0;
  assign sda_out = 1'h0;
  assign scl_oe_out = stat_r.hold;

  // Read selection
  assign rd_mux = hit(addr_in, tcc_pkg::OFF_CTLA) ? ctla_r :
                  hit(addr_in, tcc_pkg::OFF_CMDC) ? {5'h00, ack_r, 2'h0} :
                  hit(addr_in, tcc_pkg::OFF_STAT) ? stat_r :
                  hit(addr_in, tcc_pkg::OFF_OWN) ? own_r :
                  hit(addr_in, tcc_pkg::OFF_DATA) ? data_r : 8'h00;

  // Input synchronisers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scl_q <= tcc_pkg::RST_SYNC;
      sda_q <= tcc_pkg::RST_SYNC;
    end else begin
      scl_q <= {scl_q[1:0], scl_in};
      sda_q <= {sda_q[1:0], sda_in};
    end
  end

  // Engine state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r <= tcc_pkg::ST_IDLE;
      tgt_r <= tcc_pkg::ST_IDLE;
      cnt_r <= tcc_pkg::RST_CNT;
      sh_r <= tcc_pkg::RST_REG;
      nack_r <= 1'h0;
      wk_addr_r <= 1'h0;
      abort_r <= 1'h0;
      sda_oe_out <= 1'h0;
    end else begin
      st_r <= st_nxt;
      tgt_r <= tgt_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      nack_r <= nack_nxt;
      wk_addr_r <= wk_addr_nxt;
      abort_r <= abort_nxt;
      sda_oe_out <= sda_drv_nxt;
    end
  end

  // Software registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctla_r <= tcc_pkg::RST_REG;
      own_r <= tcc_pkg::RST_REG;
      data_r <= tcc_pkg::RST_REG;
      ack_r <= 1'h0;
      rdata_out <= tcc_pkg::RST_REG;
    end else begin
      ctla_r <= wr_ctla ? (wdata_in & tcc_pkg::CTLA_MASK) : ctla_r;
      own_r <= wr_own ? wdata_in : own_r;
      ack_r <= wr_cmdc ? wdata_in[tcc_pkg::B_ACK] : ack_r;
      if (dif_set && st_r == tcc_pkg::ST_RX) begin
        data_r <= sh_r;
      end else if (data_wr) begin
        data_r <= wdata_in;
      end
      rdata_out <= rd_in ? rd_mux : tcc_pkg::RST_REG;
    end
  end

  // Status flags; a set in the same cycle as a clear wins
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stat_r <= tcc_pkg::RST_REG;
      addressed_r <= 1'h0;
    end else begin
      stat_r.data_event_flag <= dif_set | (stat_r.data_event_flag & ~clr_ev & ~(wr_stat & wdata_in[tcc_pkg::B_DIF]));
      stat_r.addr_stop_event_flag <= addr_stop_event_flag_adr | addr_stop_event_flag_stop |
                     (stat_r.addr_stop_event_flag & ~clr_ev & ~(wr_stat & wdata_in[tcc_pkg::B_ADDR_STOP_EVENT_FLAG]));
      stat_r.hold <= st_nxt == tcc_pkg::ST_WAIT;
      stat_r.host_ack_received <= host_ack_received_ld ? sda_s : stat_r.host_ack_received;
      stat_r.collision_flag <= collision_flag_set | (stat_r.collision_flag & ~start_det & ~(wr_stat & wdata_in[tcc_pkg::B_COLLISION_FLAG]));
      stat_r.berr <= berr_set | (stat_r.berr & ~(wr_stat & wdata_in[tcc_pkg::B_BERR]));
      stat_r.dir <= dir_ld ? sh_r[0] : stat_r.dir;
      stat_r.ap <= addr_stop_event_flag_adr ? 1'h1 : (addr_stop_event_flag_stop ? 1'h0 : stat_r.ap);
      addressed_r <= addr_stop_event_flag_adr | (addressed_r & ~start_det & ~stop_det);
    end
  end

  // Checks
  default clocking dcb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire quiet = ctla_r[tcc_pkg::B_EN] & ~start_det & ~stop_det;

  a_smart_read_ack: assert property (
    (in_wait && !rd_phase && smart && data_rd && quiet) |=> st_r == tcc_pkg::ST_ACKO)
    else $error("smart read did not start ack");
  a_write_no_ack: assert property (
    data_wr |=> st_r != tcc_pkg::ST_ACKO)
    else $error("data write started ack");
  a_ack_level_pin: assert property (
    (in_wait && !rd_phase && cmd_resp && quiet) |=> sda_oe_out == !$past(wdata_in[tcc_pkg::B_ACK]))
    else $error("ack pin level wrong");
  a_cmd_reads_zero: assert property (
    (rd_in && hit(addr_in, tcc_pkg::OFF_CMDC)) |=> rdata_out[1:0] == 2'h0)
    else $error("command field read nonzero");
  a_nop_keeps_wait: assert property (
    (in_wait && wr_cmdc && cmd == tcc_pkg::CMD_NOP && quiet) |=> in_wait)
    else $error("no-op command acted");
  a_ack_order: assert property (
    (in_wait && !rd_phase && cmd_resp && quiet) |=> nack_r == $past(wdata_in[tcc_pkg::B_ACK]))
    else $error("ack select not updated first");
  a_flags_clear: assert property (
    (clr_ev && !dif_set && !addr_stop_event_flag_adr && !addr_stop_event_flag_stop) |=> !stat_r.data_event_flag && !stat_r.addr_stop_event_flag)
    else $error("event flags not cleared");
  a_hold_event: assert property (
    $rose(stat_r.hold) |-> (stat_r.data_event_flag || stat_r.addr_stop_event_flag) ##1 scl_oe_out)
    else $error("clock hold without event");
  a_collision_flag_start: assert property (
    (start_det && !collision_flag_set) |=> !stat_r.collision_flag)
    else $error("collision not cleared by start");
  a_bus_error: assert property (
    (stop_det && bare_start) |=> stat_r.berr)
    else $error("start then stop not flagged");
  a_dir_cause: assert property (
    dir_ld |=> stat_r.dir == $past(sh_r[0]) && stat_r.ap && stat_r.addr_stop_event_flag)
    else $error("direction or cause wrong");

  c_address: cover property (addr_stop_event_flag_adr);
  c_tx_done: cover property (dif_set && st_r == tcc_pkg::ST_TACK);
  c_collision: cover property (collision_flag_set);
  c_bus_error: cover property (berr_set);
endmodule : tcc_client

// ### tcc_host_model.sv
// Two-wire bus host model with open-drain releases and stretch handling
`timescale 1ns/10ps
module tcc_host_model (
  // Clock
  input wire logic clk_in,
  // Bus wire levels
  input wire logic scl_in,
  input wire logic sda_in,
  // Releases, high lets the pull-up win
  output logic scl_out,
  output logic sda_out
);
  int hangs = 0;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // Quarter serial period, main clock eight times SCL
  task automatic tick();
    repeat (2) @(posedge clk_in);
  endtask : tick
  // Release SCL, then wait out any clock stretch
  task automatic rise();
    int n;
    n = 0;
    scl_out <= 1'b1;
    tick();
    while (scl_in !== 1'b1 && n < 400) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 400) hangs++;
    tick();
  endtask : rise
  task automatic xfer(input logic b, output logic r);
    sda_out <= b;
    tick();
    rise();
    r = sda_in;
    scl_out <= 1'b0;
    tick();
  endtask : xfer
  // MSB first; drive 0xFF to only listen
  task automatic byte_x(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) xfer(d[i], q[i]);
  endtask : byte_x
  task automatic start();
    sda_out <= 1'b1;
    tick();
    rise();
    sda_out <= 1'b0;
    tick();
    scl_out <= 1'b0;
    tick();
  endtask : start
  task automatic stop();
    sda_out <= 1'b0;
    tick();
    rise();
    sda_out <= 1'b1;
    tick();
  endtask : stop
endmodule : tcc_host_model

// ### tcc_pkg.sv
// Constants and types for the two-wire client command and status block
package tcc_pkg;
  // Register offsets
  localparam logic [3:0] OFF_CTLA = 4'h9;
  localparam logic [3:0] OFF_CMDC = 4'hA;
  localparam logic [3:0] OFF_STAT = 4'hB;
  localparam logic [3:0] OFF_OWN = 4'hC;
  localparam logic [3:0] OFF_DATA = 4'hD;
  // Reset values and the control A write mask
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [2:0] RST_SYNC = 3'h7;
  localparam logic [3:0] RST_CNT = 4'h0;
  localparam logic [7:0] CTLA_MASK = 8'hE7;
  // Control A bit positions
  localparam int B_EN = 0;
  localparam int B_SMART = 1;
  localparam int B_PERM = 2;
  localparam int B_STOPIE = 5;
  // Command control bit positions and commands
  localparam int B_ACK = 2;
  localparam logic [1:0] CMD_NOP = 2'h0;
  localparam logic [1:0] CMD_DONE = 2'h2;
  localparam logic [1:0] CMD_RESP = 2'h3;
  // Status bit positions
  localparam int B_DIF = 7;
  localparam int B_ADDR_STOP_EVENT_FLAG = 6;
  localparam int B_COLLISION_FLAG = 3;
  localparam int B_BERR = 2;
  // Bits per byte and the general call address
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [6:0] GCALL_ADDR = 7'h00;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_RX = 7'h04,
    ST_ACKO = 7'h08,
    ST_TX = 7'h10,
    ST_TACK = 7'h20,
    ST_WAIT = 7'h40
  } tcc_state_t;

  typedef struct packed {
    logic data_event_flag;
    logic addr_stop_event_flag;
    logic hold;
    logic host_ack_received;
    logic collision_flag;
    logic berr;
    logic dir;
    logic ap;
  } tcc_status_t;
endpackage : tcc_pkg
